// ==== rtl/pafm_mux.sv ====
// port alternate-function mux with axi4-lite configuration
//
// Our own choices: register access over AXI4-Lite and the address map.
`include "pafm_params.svh"
module pafm_mux (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              xtal_enable,
  input  wire logic              timer0_out_mode,
  input  wire logic              timer0_true_out,
  input  wire logic              timer0_comp_out,
  input  wire logic              timer1_out_mode,
  input  wire logic              timer1_true_out,
  input  wire logic              timer1_comp_out,
  input  wire logic              comparator_output,
  input  wire logic [7:0]        port_a_in,
  input  wire logic [7:0]        port_b_in,
  input  wire logic [7:0]        port_c_in,
  output pafm_pkg::pafm_pin_t    port_a_pin,
  output pafm_pkg::pafm_pin_t    port_c_pin,
  output logic                   timer0_in,
  output logic                   timer1_in,
  output logic                   external_clock_input,
  output logic [7:0]             analog_sel,
  output logic                   analog_ref_sel,
  output logic                   comp_positive_sel,
  output logic                   comp_negative_sel,
  output logic                   xtal_pins_own,
  output logic                   port_d_bit0_reset_mode
);
  import pafm_pkg::*;

  // configuration state
  logic [7:0]  a_en_r, a_en_nxt;
  pafm_cfg_t   b_cfg_r, b_cfg_nxt;
  pafm_cfg_t   c_cfg_r, c_cfg_nxt;
  logic        d_en_r, d_en_nxt;
  // bus state
  pafm_wst_t   wst_r, wst_nxt;
  logic        aw_got_r, aw_got_nxt;
  logic        w_got_r, w_got_nxt;
  logic [3:0]  waddr_r, waddr_nxt;
  logic [7:0]  wdat_r, wdat_nxt;
  logic        wstb_r, wstb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        wr_map_ok;
  logic        rd_map_ok;
  logic [7:0]  rd_val;
  logic [3:0]  raddr;
  // pin sync: three stages, change accepted when stage 2 and 3 agree
  logic [7:0]  a_s1_r, a_s2_r, a_s3_r, a_q_r, a_q_nxt;
  logic [7:0]  b_s1_r, b_s2_r, b_s3_r, b_q_r, b_q_nxt;
  // mux outputs
  pafm_pin_t   pa_nxt, pc_nxt;
  logic        t0i_nxt, t1i_nxt, clki_nxt;
  logic [7:0]  ana_nxt;
  logic        ref_nxt, cinp_nxt, cinn_nxt;
  logic [7:0]  b_act, c_act;

  assign raddr = s_axi_araddr[5:2];
  assign wr_map_ok = (waddr_r <= `PAFM_OFF_D_EN);

  // register write path; write and read share no state
  always_comb begin
    wst_nxt    = wst_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    waddr_nxt  = waddr_r;
    wdat_nxt   = wdat_r;
    wstb_nxt   = wstb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    a_en_nxt   = a_en_r;
    b_cfg_nxt  = b_cfg_r;
    c_cfg_nxt  = c_cfg_r;
    d_en_nxt   = d_en_r;
    case (wst_r)
      PAFM_W_IDLE: begin
        // take a beat only on a real handshake, never twice
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got_nxt = 1'b1;
          waddr_nxt  = s_axi_awaddr[5:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got_nxt = 1'b1;
          wdat_nxt  = s_axi_wdata[7:0];
          wstb_nxt  = s_axi_wstrb[0];
        end
        if (aw_got_r && w_got_r) begin
          // only byte lane 0 holds data; upper lanes ignored
          if (wstb_r) begin
            case (waddr_r)
              `PAFM_OFF_A_EN:   a_en_nxt = wdat_r;
              `PAFM_OFF_B_EN:   b_cfg_nxt.en = wdat_r;
              `PAFM_OFF_B_SET1: b_cfg_nxt.set1 = wdat_r;
              `PAFM_OFF_B_SET2: b_cfg_nxt.set2 = wdat_r;
              `PAFM_OFF_C_EN:   c_cfg_nxt.en = wdat_r;
              `PAFM_OFF_C_SET1: c_cfg_nxt.set1 = wdat_r;
              `PAFM_OFF_C_SET2: c_cfg_nxt.set2 = wdat_r;
              `PAFM_OFF_D_EN:   d_en_nxt = wdat_r[0];
              default: ;
            endcase
          end
          bresp_nxt  = wr_map_ok ? `PAFM_RESP_OKAY : `PAFM_RESP_SLVERR;
          bvalid_nxt = 1'b1;
          aw_got_nxt = 1'b0;
          w_got_nxt  = 1'b0;
          wst_nxt    = PAFM_W_RESP;
        end
      end
      PAFM_W_RESP: begin
        if (s_axi_bready) begin
          bvalid_nxt = 1'b0;
          wst_nxt    = PAFM_W_IDLE;
        end
      end
      default: wst_nxt = PAFM_W_IDLE;
    endcase
  end

  // read path; status shows xtal_enable (bit 1) and port_d_bit0_reset_mode (bit 0)
  always_comb begin
    rd_map_ok = 1'b1;
    case (raddr)
      `PAFM_OFF_A_EN:   rd_val = a_en_r;
      `PAFM_OFF_B_EN:   rd_val = b_cfg_r.en;
      `PAFM_OFF_B_SET1: rd_val = b_cfg_r.set1;
      `PAFM_OFF_B_SET2: rd_val = b_cfg_r.set2;
      `PAFM_OFF_C_EN:   rd_val = c_cfg_r.en;
      `PAFM_OFF_C_SET1: rd_val = c_cfg_r.set1;
      `PAFM_OFF_C_SET2: rd_val = c_cfg_r.set2;
      `PAFM_OFF_D_EN:   rd_val = {7'h00, d_en_r};
      `PAFM_OFF_STATUS: rd_val = {6'h00, xtal_enable, port_d_bit0_reset_mode};
      default: begin
        rd_val    = 8'h00;
        rd_map_ok = 1'b0;
      end
    endcase
    if (s_axi_araddr[31:6] != 26'h0000000) begin
      rd_val    = 8'h00;
      rd_map_ok = 1'b0;
    end
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_nxt = 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, rd_val};
      rresp_nxt  = rd_map_ok ? `PAFM_RESP_OKAY : `PAFM_RESP_SLVERR;
    end
  end

  // function mapping
  always_comb begin
    // port b/c: function only while enable set
    b_act = b_cfg_r.en & b_cfg_r.set1;
    c_act = c_cfg_r.en & c_cfg_r.set1;
    // port a: enable selects the function; on a0/a6 the timer out mode picks output over input
    pa_nxt = '0;
    pa_nxt.o[0]  = timer0_comp_out;
    pa_nxt.oe[0] = a_en_r[0] & timer0_out_mode;
    pa_nxt.o[1]  = timer0_true_out;
    pa_nxt.oe[1] = a_en_r[1];
    pa_nxt.o[6]  = timer1_comp_out;
    pa_nxt.oe[6] = a_en_r[6] & timer1_out_mode;
    pa_nxt.o[7]  = timer1_true_out;
    pa_nxt.oe[7] = a_en_r[7];
    // crystal owns a0/a1 whatever the port settings
    if (xtal_enable) begin
      pa_nxt.o[1:0]  = 2'b00;
      pa_nxt.oe[1:0] = 2'b00;
    end
    // undriven pins show no peripheral level
    pa_nxt.o = pa_nxt.o & pa_nxt.oe;
    t0i_nxt = a_en_r[0] & ~timer0_out_mode & ~xtal_enable &
              a_q_r[0];
    t1i_nxt = a_en_r[6] & ~timer1_out_mode & a_q_r[6];
    // b3 clock input: enable set and set bit clear
    clki_nxt = b_cfg_r.en[3] & ~b_cfg_r.set1[3] & b_q_r[3];
    ana_nxt = '0;
    ana_nxt[0] = b_act[0];
    ana_nxt[1] = b_act[1];
    ana_nxt[2] = b_act[2];
    ana_nxt[3] = b_act[3];
    ana_nxt[7] = b_act[4];
    ana_nxt[4] = c_act[0];
    ana_nxt[5] = c_act[1];
    ana_nxt[6] = c_act[2];
    ref_nxt  = b_act[5];
    cinp_nxt = c_act[0];
    cinn_nxt = c_act[1];
    pc_nxt = '0;
    pc_nxt.o[3]  = comparator_output;
    pc_nxt.oe[3] = c_cfg_r.en[3] & ~c_cfg_r.set1[3];
    pc_nxt.o = pc_nxt.o & pc_nxt.oe;
    // a pin in the three-stage sync moves once stages 2 and 3 agree
    a_q_nxt = a_q_r;
    b_q_nxt = b_q_r;
    for (int i = 0; i < 8; i++) begin
      if (a_s2_r[i] == a_s3_r[i]) a_q_nxt[i] = a_s3_r[i];
      if (b_s2_r[i] == b_s3_r[i]) b_q_nxt[i] = b_s3_r[i];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wst_r    <= PAFM_W_IDLE;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      waddr_r  <= 4'h0;
      wdat_r   <= 8'h00;
      wstb_r   <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= `PAFM_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `PAFM_RESP_OKAY;
      a_en_r   <= `PAFM_RST_EN;
      b_cfg_r  <= '{`PAFM_RST_EN, `PAFM_RST_SET, `PAFM_RST_SET};
      c_cfg_r  <= '{`PAFM_RST_EN, `PAFM_RST_SET, `PAFM_RST_SET};
      d_en_r   <= `PAFM_RST_D_EN;
      a_s1_r <= 8'h00; a_s2_r <= 8'h00; a_s3_r <= 8'h00; a_q_r <= 8'h00;
      b_s1_r <= 8'h00; b_s2_r <= 8'h00; b_s3_r <= 8'h00; b_q_r <= 8'h00;
      port_a_pin             <= '0;
      port_c_pin             <= '0;
      timer0_in              <= 1'b0;
      timer1_in              <= 1'b0;
      external_clock_input   <= 1'b0;
      analog_sel             <= 8'h00;
      analog_ref_sel         <= 1'b0;
      comp_positive_sel      <= 1'b0;
      comp_negative_sel      <= 1'b0;
      xtal_pins_own          <= 1'b0;
      port_d_bit0_reset_mode <= 1'b1;
    end else if (clk_en) begin
      wst_r    <= wst_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      waddr_r  <= waddr_nxt;
      wdat_r   <= wdat_nxt;
      wstb_r   <= wstb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
      a_en_r   <= a_en_nxt;
      b_cfg_r  <= b_cfg_nxt;
      c_cfg_r  <= c_cfg_nxt;
      d_en_r   <= d_en_nxt;
      a_s1_r <= port_a_in; a_s2_r <= a_s1_r; a_s3_r <= a_s2_r;
      a_q_r  <= a_q_nxt;
      b_s1_r <= port_b_in; b_s2_r <= b_s1_r; b_s3_r <= b_s2_r;
      b_q_r  <= b_q_nxt;
      port_a_pin             <= pa_nxt;
      port_c_pin             <= pc_nxt;
      timer0_in              <= t0i_nxt;
      timer1_in              <= t1i_nxt;
      external_clock_input   <= clki_nxt;
      analog_sel             <= ana_nxt;
      analog_ref_sel         <= ref_nxt;
      comp_positive_sel      <= cinp_nxt;
      comp_negative_sel      <= cinn_nxt;
      xtal_pins_own          <= xtal_enable;
      port_d_bit0_reset_mode <= d_en_nxt;
    end
  end

  // handshake readies are flops too; one beat each per write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= (wst_nxt == PAFM_W_IDLE) & ~aw_got_nxt &
                       ~(aw_got_r & w_got_r);
      s_axi_wready  <= (wst_nxt == PAFM_W_IDLE) & ~w_got_nxt &
                       ~(aw_got_r & w_got_r);
      s_axi_arready <= ~rvalid_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
endmodule : pafm_mux

// ==== rtl/pafm_params.svh ====
// constants for the port alternate-function mux
`ifndef PAFM_PARAMS_SVH
`define PAFM_PARAMS_SVH
`define PAFM_ADDR_W        4
`define PAFM_OFF_A_EN      4'h0
`define PAFM_OFF_B_EN      4'h1
`define PAFM_OFF_B_SET1    4'h2
`define PAFM_OFF_B_SET2    4'h3
`define PAFM_OFF_C_EN      4'h4
`define PAFM_OFF_C_SET1    4'h5
`define PAFM_OFF_C_SET2    4'h6
`define PAFM_OFF_D_EN      4'h7
`define PAFM_OFF_STATUS    4'h8
`define PAFM_RST_EN        8'h00
`define PAFM_RST_SET       8'h00
`define PAFM_RST_D_EN      1'b1
`define PAFM_RESP_OKAY     2'b00
`define PAFM_RESP_SLVERR   2'b10
`endif

// ==== rtl/pafm_pkg.sv ====
// types for the port alternate-function mux
package pafm_pkg;
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] set1;
    logic [7:0] set2;
  } pafm_cfg_t;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pafm_pin_t;
  typedef enum logic [1:0] {PAFM_W_IDLE, PAFM_W_RESP} pafm_wst_t;
endpackage : pafm_pkg

// ==== test/pafm_periph_model.sv ====
// timer and comparator stand-in on the mux's peripheral side
module pafm_periph_model (
  input wire logic clk,
  output logic     timer0_true_out,
  output logic     timer0_comp_out,
  output logic     timer1_true_out,
  output logic     timer1_comp_out,
  output logic     comparator_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r = 3'h0;
  // timer0 levels move every cycle, timer1 every two, the comparator every four, so a stale or swapped route shows
  always @(posedge clk) cnt_r <= cnt_r + 3'h1;
  assign timer0_true_out   = cnt_r[0];
  assign timer0_comp_out   = ~cnt_r[0];
  assign timer1_true_out   = cnt_r[1];
  assign timer1_comp_out   = ~cnt_r[1];
  assign comparator_output = cnt_r[1] ^ cnt_r[2];
endmodule : pafm_periph_model

// ==== test/pafm_props.sv ====
// assertion checker for the alternate-function mux
module pafm_props (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                xtal_enable,
  input wire logic                timer0_out_mode,
  input wire logic                timer0_true_out,
  input wire logic                timer0_comp_out,
  input wire logic                timer1_out_mode,
  input wire logic                timer1_true_out,
  input wire logic                timer1_comp_out,
  input wire logic                comparator_output,
  input wire pafm_pkg::pafm_pin_t port_a_pin,
  input wire pafm_pkg::pafm_pin_t port_c_pin,
  input wire logic                timer0_in,
  input wire logic [7:0]          analog_sel,
  input wire logic                comp_positive_sel,
  input wire logic                comp_negative_sel,
  input wire logic                xtal_pins_own,
  input wire logic                port_d_bit0_reset_mode
);
  import pafm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // first edge after release still shows reset values
  a_xtal_copy: assert property ($past(rst_b) |->
    xtal_pins_own == $past(xtal_enable)) else $error("xtal copy");
  a_xtal_frees: assert property ($past(xtal_enable) |->
    port_a_pin.oe[1:0] == 2'h0) else $error("xtal pins");
  a_a_mid_none: assert property (port_a_pin.oe[5:2] == 4'h0)
    else $error("a2-a5 driven");
  a_a1_true: assert property (port_a_pin.oe[1] |->
    port_a_pin.o[1] == $past(timer0_true_out)) else $error("a1");
  a_a0_comp: assert property (port_a_pin.oe[0] |-> $past(timer0_out_mode)
    && port_a_pin.o[0] == $past(timer0_comp_out)) else $error("a0");
  a_a7_true: assert property (port_a_pin.oe[7] |->
    port_a_pin.o[7] == $past(timer1_true_out)) else $error("a7");
  a_a6_comp: assert property (port_a_pin.oe[6] |-> $past(timer1_out_mode)
    && port_a_pin.o[6] == $past(timer1_comp_out)) else $error("a6");
  a_c3_comp: assert property (port_c_pin.oe[3] |->
    port_c_pin.o[3] == $past(comparator_output)) else $error("c3");
  a_c_empty: assert property ((port_c_pin.oe & 8'hf7) == 8'h0)
    else $error("empty c entry driven");
  a_idle_low: assert property ((port_a_pin.o & ~port_a_pin.oe) == 8'h0 &&
    (port_c_pin.o & ~port_c_pin.oe) == 8'h0) else $error("idle o");
  a_t0_input: assert property (timer0_in |-> !$past(timer0_out_mode))
    else $error("timer0 input in output mode");
  a_shared_in: assert property (analog_sel[5:4] ==
    {comp_negative_sel, comp_positive_sel}) else $error("shared");
  a_d_reset: assert property ($rose(rst_b) |-> port_d_bit0_reset_mode)
    else $error("pin d0 not reset function");
endmodule : pafm_props
bind pafm_mux pafm_props i_pafm_props (.*);

// ==== test/test_port_alternate_function_mux.sv ====
// self-checking bench for the alternate-function mux
`include "pafm_params.svh"
module test_port_alternate_function_mux;
  timeunit 1ns;
  timeprecision 1ps;
  import pafm_pkg::*;
  logic clk, rst_b, clk_en, xtal_enable, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic timer0_out_mode, timer0_true_out, timer0_comp_out, timer1_in;
  logic timer1_out_mode, timer1_true_out, timer1_comp_out, timer0_in;
  logic comparator_output, external_clock_input, analog_ref_sel;
  logic comp_positive_sel, comp_negative_sel, xtal_pins_own;
  logic port_d_bit0_reset_mode;
  logic [7:0]  port_a_in, port_b_in, port_c_in, analog_sel;
  logic [31:0] rd;
  pafm_pin_t   port_a_pin, port_c_pin;
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  pafm_mux i_pafm_mux (.*);
  pafm_periph_model i_pafm_periph_model (.*);
  initial clk = 1'h0;
  always #2.5 clk = ~clk;
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n
  // valids drop only at the edge that takes them
  task automatic wr(input logic [3:0] o, input logic [31:0] d);
    s_axi_awaddr  <= {26'h0, o, 2'h0};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rs = s_axi_bresp;
    wait_n(2);
  endtask : wr
  task automatic rd_reg(input logic [3:0] o);
    s_axi_araddr  <= {26'h0, o, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready  <= 1'h0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
  endtask : rd_reg
  initial begin
    {rst_b, xtal_enable, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, timer0_out_mode, timer1_out_mode} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {port_a_in, port_b_in, port_c_in} = 24'h0;
    clk_en = 1'h1;
    s_axi_wstrb = 4'hf;
    wait_n(8);
    rst_b <= 1'h1;
    @(posedge clk);
    chk(port_d_bit0_reset_mode, 32'h1);
    for (int i = 0; i < 10; i++) begin
      rd_reg(i[3:0]);
      chk(rd, (i == 7 || i == 8) ? 32'h1 : 32'h0);
      chk(rs, i == 9 ? `PAFM_RESP_SLVERR : `PAFM_RESP_OKAY);
    end
    wr(`PAFM_OFF_STATUS, 32'hff);
    chk(rs, `PAFM_RESP_SLVERR);
    timer1_out_mode <= 1'h1;
    port_a_in <= 8'h01;
    wr(`PAFM_OFF_A_EN, 32'hff);
    wait_n(6);
    chk(port_a_pin.oe, 8'hc2);
    chk(timer0_in, 32'h1);
    chk(timer1_in, 32'h0);
    timer0_out_mode <= 1'h1;
    wait_n(2);
    chk(port_a_pin.oe, 8'hc3);
    chk(timer0_in, 32'h0);
    xtal_enable <= 1'h1;
    wait_n(2);
    chk(port_a_pin.oe, 8'hc0);
    chk(xtal_pins_own, 32'h1);
    xtal_enable <= 1'h0;
    // clock source switch itself lies outside this block
    port_b_in <= 8'h08;
    wr(`PAFM_OFF_B_SET2, 32'hff);
    wr(`PAFM_OFF_B_EN, 32'h3f);
    wait_n(6);
    chk(external_clock_input, 32'h1);
    chk(analog_sel, 32'h0);
    wr(`PAFM_OFF_B_SET1, 32'h3f);
    chk(analog_sel, 32'h8f);
    chk({analog_ref_sel, external_clock_input}, 32'h2);
    wr(`PAFM_OFF_B_EN, 32'h0);
    chk({analog_ref_sel, analog_sel}, 32'h0);
    wr(`PAFM_OFF_C_SET2, 32'hff);
    wr(`PAFM_OFF_C_EN, 32'h0f);
    chk(port_c_pin.oe, 8'h08);
    wr(`PAFM_OFF_C_SET1, 32'h0f);
    chk(analog_sel, 32'h70);
    chk({comp_negative_sel, comp_positive_sel}, 32'h3);
    chk(port_c_pin.oe, 8'h00);
    s_axi_wstrb <= 4'he;
    wr(`PAFM_OFF_D_EN, 32'h0);
    chk(rs, `PAFM_RESP_OKAY);
    chk(port_d_bit0_reset_mode, 32'h1);
    s_axi_wstrb <= 4'hf;
    wr(`PAFM_OFF_D_EN, 32'h0);
    chk(port_d_bit0_reset_mode, 32'h0);
    rst_b <= 1'h0;
    wait_n(2);
    rst_b <= 1'h1;
    @(posedge clk);
    chk(port_d_bit0_reset_mode, 32'h1);
    report_and_stop();
  end
endmodule : test_port_alternate_function_mux
